// file: rtl/adc_control.sv
// Purpose: Register file and control around a 12-bit SAR converter
// Assumes: Comparator, reference and input switches sit in the analog core
// Notes: Registers sit at byte offsets on a plain 8-bit port
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module adc_control (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // System side
    input wire logic pwm_generator_enable_i,
    input wire logic irq_ack_i,
    output logic irq_o,
    output logic wake_o,
    // Analog core side
    input wire logic compare_i,
    output logic converter_enable_o,
    output logic sample_o,
    output logic [adc_pkg::RESULT_BITS-1:0] trial_code_o,
    output logic [3:0] channel_select_o,
    output logic [adc_pkg::EXT_CHANNELS-1:0] ext_channel_en_o,
    output logic opamp_channel_en_o,
    output logic battery_channel_en_o,
    output logic external_reference_select_o,
    output logic [1:0] internal_reference_select_o,
    // Pin isolation
    output logic [7:0] port1_analog_config_o,
    output logic [7:0] port2_analog_config_o
);
    import adc_pkg::*;

    sar_if link (); // Control to sequencer

    // Software-owned state
    logic converter_enable_r, converter_enable_nxt; // Converter on
    logic eoc_r, eoc_nxt; // End-of-conversion status
    logic [3:0] channel_select_r, channel_select_nxt; // Input code
    logic ctrl_rsv_r, ctrl_rsv_nxt; // Spare read/write bit
    logic global_channel_enable_r, global_channel_enable_nxt; // Input switch on
    logic [1:0] converter_clock_select_r, converter_clock_select_nxt; // Divider code
    logic external_reference_select_r, external_reference_select_nxt; // Reference pin
    logic pwm_trigger_enable_r, pwm_trigger_enable_nxt; // PWM start allowed
    logic [2:0] internal_reference_select_r, internal_reference_select_nxt; // Ref field
    logic [7:0] port1_analog_config_r, port1_analog_config_nxt; // Pin isolation
    logic [7:0] port2_analog_config_r, port2_analog_config_nxt; // Pin isolation
    logic converter_irq_enable_r, converter_irq_enable_nxt; // Interrupt gate
    logic converter_irq_flag_r, converter_irq_flag_nxt; // Interrupt request flag
    logic wake_r, wake_nxt; // Wake pulse
    logic [7:0] rdata_r, rdata_nxt; // Read data
    // Derived analog controls
    logic [EXT_CHANNELS-1:0] ext_channel_en_r, ext_channel_en_nxt;
    logic opamp_channel_en_r, opamp_channel_en_nxt;
    logic battery_channel_en_r, battery_channel_en_nxt;
    // Result buffer, deliberately without reset
    logic [RESULT_BITS-1:0] result_r, result_nxt;
    // Decoded accesses
    logic wr_mode; // Write to mode register
    logic sw_start; // Software start request
    logic pwm_start; // PWM start request
    logic [7:0] mode_read; // Mode register as read

    // Write decode and start requests
    always_comb begin
        wr_mode = wr_i && (addr_i == MODE_ADDR);
        // New enable value counts, so enable and start may share a write
        sw_start = wr_mode && wdata_i[MODE_START_BIT] && wdata_i[MODE_EN_BIT];
        // Level trigger: each finish is followed by a restart while PWM runs
        pwm_start = pwm_trigger_enable_r && converter_enable_r
            && pwm_generator_enable_i;
    end

    // Requests to the sequencer; it ignores start while busy
    assign link.start = (sw_start || pwm_start) && !link.busy;
    // Clearing the enable drops a running conversion
    assign link.abort = !converter_enable_r;
    assign link.div_sel = converter_clock_select_r;

    // Register writes and hardware events
    always_comb begin
        converter_enable_nxt = converter_enable_r;
        eoc_nxt = eoc_r;
        channel_select_nxt = channel_select_r;
        ctrl_rsv_nxt = ctrl_rsv_r;
        global_channel_enable_nxt = global_channel_enable_r;
        converter_clock_select_nxt = converter_clock_select_r;
        external_reference_select_nxt = external_reference_select_r;
        pwm_trigger_enable_nxt = pwm_trigger_enable_r;
        internal_reference_select_nxt = internal_reference_select_r;
        port1_analog_config_nxt = port1_analog_config_r;
        port2_analog_config_nxt = port2_analog_config_r;
        converter_irq_enable_nxt = converter_irq_enable_r;
        converter_irq_flag_nxt = converter_irq_flag_r;
        result_nxt = result_r;
        if (wr_i) begin
            case (addr_i)
                MODE_ADDR: begin
                    converter_enable_nxt = wdata_i[MODE_EN_BIT];
                    // Writing 1 to the status has no effect
                    if (!wdata_i[MODE_EOC_BIT]) begin
                        eoc_nxt = 1'b0;
                    end
                    channel_select_nxt = wdata_i[3:0];
                end
                RESULT_LOW_ADDR: begin
                    // Result nibble below is not writable
                    ctrl_rsv_nxt = wdata_i[CTRL_RSV_BIT];
                    global_channel_enable_nxt = wdata_i[CTRL_CHAN_EN_BIT];
                    converter_clock_select_nxt = wdata_i[CTRL_CLK_LSB +: 2];
                end
                REFERENCE_ADDR: begin
                    external_reference_select_nxt = wdata_i[REF_EXT_BIT];
                    pwm_trigger_enable_nxt = wdata_i[REF_PWM_BIT];
                    internal_reference_select_nxt = wdata_i[REF_VDD_BIT:0];
                end
                PORT1_CFG_ADDR: port1_analog_config_nxt = wdata_i & PORT1_CFG_MASK;
                PORT2_CFG_ADDR: port2_analog_config_nxt = wdata_i & PORT2_CFG_MASK;
                IRQ_ENABLE_ADDR: converter_irq_enable_nxt = wdata_i[IRQ_ENABLE_BIT];
                IRQ_FLAG_ADDR: begin
                    if (!wdata_i[IRQ_FLAG_BIT]) begin
                        converter_irq_flag_nxt = 1'b0;
                    end
                end
                default: begin
                    // Unmapped or read-only: nothing stored
                end
            endcase
        end
        // Service of the interrupt clears the flag without software
        if (irq_ack_i) begin
            converter_irq_flag_nxt = 1'b0;
        end
        // Completion beats any clear in the same cycle
        if (link.done) begin
            eoc_nxt = 1'b1;
            converter_irq_flag_nxt = 1'b1;
            result_nxt = link.result;
        end
    end

    // Channel switch decode, one enable per external input
    generate
        for (genvar ch = 0; ch < EXT_CHANNELS; ch++) begin : g_chan
            // Reserved codes match no input
            assign ext_channel_en_nxt[ch] = global_channel_enable_r
                && (channel_select_r == 4'(ch));
        end
    endgenerate

    // Internal sources share the same gate
    always_comb begin
        opamp_channel_en_nxt = global_channel_enable_r
            && (channel_select_r == CH_OPAMP);
        battery_channel_en_nxt = global_channel_enable_r
            && (channel_select_r == CH_BATTERY);
        // Wake only when the finish will be taken as an interrupt
        wake_nxt = link.done && converter_irq_enable_r;
    end

    // Read mux; status masked while busy, data only in the next cycle
    always_comb begin
        mode_read = {converter_enable_r, link.busy, eoc_r && !link.busy, 1'b0,
            channel_select_r};
        rdata_nxt = 8'h00;
        if (rd_i) begin
            case (addr_i)
                MODE_ADDR: rdata_nxt = mode_read;
                RESULT_HIGH_ADDR: rdata_nxt = result_r[RESULT_BITS-1:4];
                RESULT_LOW_ADDR: rdata_nxt = {ctrl_rsv_r, global_channel_enable_r,
                    converter_clock_select_r, result_r[3:0]};
                REFERENCE_ADDR: rdata_nxt = {external_reference_select_r, 2'h0,
                    pwm_trigger_enable_r, 1'b0, internal_reference_select_r};
                PORT1_CFG_ADDR: rdata_nxt = port1_analog_config_r;
                PORT2_CFG_ADDR: rdata_nxt = port2_analog_config_r;
                IRQ_ENABLE_ADDR: rdata_nxt = {6'h00, converter_irq_enable_r, 1'b0};
                IRQ_FLAG_ADDR: rdata_nxt = {7'h00, converter_irq_flag_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Control registers with reset
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            converter_enable_r <= 1'b0;
            eoc_r <= 1'b0;
            channel_select_r <= CHANNEL_RESET;
            ctrl_rsv_r <= 1'b0;
            global_channel_enable_r <= 1'b0;
            converter_clock_select_r <= CLK_SEL_RESET;
            external_reference_select_r <= 1'b0;
            pwm_trigger_enable_r <= 1'b0;
            internal_reference_select_r <= INT_REF_RESET;
            port1_analog_config_r <= PORT_CFG_RESET;
            port2_analog_config_r <= PORT_CFG_RESET;
            converter_irq_enable_r <= 1'b0;
            converter_irq_flag_r <= 1'b0;
            wake_r <= 1'b0;
            rdata_r <= 8'h00;
            ext_channel_en_r <= '0;
            opamp_channel_en_r <= 1'b0;
            battery_channel_en_r <= 1'b0;
        end else begin
            converter_enable_r <= converter_enable_nxt;
            eoc_r <= eoc_nxt;
            channel_select_r <= channel_select_nxt;
            ctrl_rsv_r <= ctrl_rsv_nxt;
            global_channel_enable_r <= global_channel_enable_nxt;
            converter_clock_select_r <= converter_clock_select_nxt;
            external_reference_select_r <= external_reference_select_nxt;
            pwm_trigger_enable_r <= pwm_trigger_enable_nxt;
            internal_reference_select_r <= internal_reference_select_nxt;
            port1_analog_config_r <= port1_analog_config_nxt;
            port2_analog_config_r <= port2_analog_config_nxt;
            converter_irq_enable_r <= converter_irq_enable_nxt;
            converter_irq_flag_r <= converter_irq_flag_nxt;
            wake_r <= wake_nxt;
            rdata_r <= rdata_nxt;
            ext_channel_en_r <= ext_channel_en_nxt;
            opamp_channel_en_r <= opamp_channel_en_nxt;
            battery_channel_en_r <= battery_channel_en_nxt;
        end
    end

    // Result buffer keeps no reset value, so it is unknown until filled
    always_ff @(posedge clock_i) begin
        result_r <= result_nxt;
    end

    // Timing, divider and bit search
    sar_sequencer u_seq (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ctl(link.seq),
        .compare_i(compare_i),
        .trial_code_o(trial_code_o),
        .sample_o(sample_o)
    );

    // Interrupt request straight from registers
    assign irq_o = converter_irq_enable_r && converter_irq_flag_r;
    assign wake_o = wake_r;
    assign rdata_o = rdata_r;
    // No clock gating here, so conversions run on through idle
    assign converter_enable_o = converter_enable_r;
    assign channel_select_o = channel_select_r;
    assign ext_channel_en_o = ext_channel_en_r;
    assign opamp_channel_en_o = opamp_channel_en_r;
    assign battery_channel_en_o = battery_channel_en_r;
    // Reference: pin when external, else field; top field bit forces supply
    assign external_reference_select_o = external_reference_select_r;
    assign internal_reference_select_o = internal_reference_select_r[REF_VDD_BIT]
        ? REF_SUPPLY : internal_reference_select_r[1:0];
    // A set bit isolates the digital input buffer of that pin
    assign port1_analog_config_o = port1_analog_config_r;
    assign port2_analog_config_o = port2_analog_config_r;
endmodule

// file: shared/adc_pkg.sv
// Purpose: Shared constants and types for the SAR converter control logic
// Assumes: 8-bit register port, registers at their byte offsets
// Notes: Offsets, field positions, reset values and timing counts live here
package adc_pkg;
    // Register offsets
    localparam logic [7:0] MODE_ADDR = 8'hD2;
    localparam logic [7:0] RESULT_HIGH_ADDR = 8'hD3;
    localparam logic [7:0] RESULT_LOW_ADDR = 8'hD4;
    localparam logic [7:0] REFERENCE_ADDR = 8'hD5;
    localparam logic [7:0] PORT1_CFG_ADDR = 8'hD6;
    localparam logic [7:0] PORT2_CFG_ADDR = 8'hD7;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h9A;
    localparam logic [7:0] IRQ_FLAG_ADDR = 8'hBF;
    // Field positions
    localparam int MODE_EN_BIT = 7;
    localparam int MODE_START_BIT = 6;
    localparam int MODE_EOC_BIT = 5;
    localparam int CTRL_RSV_BIT = 7;
    localparam int CTRL_CHAN_EN_BIT = 6;
    localparam int CTRL_CLK_LSB = 4;
    localparam int REF_EXT_BIT = 7;
    localparam int REF_PWM_BIT = 4;
    localparam int REF_VDD_BIT = 2;
    localparam int IRQ_ENABLE_BIT = 1;
    localparam int IRQ_FLAG_BIT = 0;
    // Values after reset
    localparam logic [3:0] CHANNEL_RESET = 4'h0;
    localparam logic [1:0] CLK_SEL_RESET = 2'h0;
    localparam logic [2:0] INT_REF_RESET = 3'h0;
    localparam logic [7:0] PORT_CFG_RESET = 8'h00;
    // Writable bits of the pin configuration registers
    localparam logic [7:0] PORT1_CFG_MASK = 8'hFE;
    localparam logic [7:0] PORT2_CFG_MASK = 8'h3F;
    // Channel map
    localparam int RESULT_BITS = 12;
    localparam int EXT_CHANNELS = 11;
    localparam logic [3:0] CH_OPAMP = 4'hB;
    localparam logic [3:0] CH_BATTERY = 4'hC;
    // Internal reference code that means the supply
    localparam logic [1:0] REF_SUPPLY = 2'h3;
    // Converter clock select codes and their divide ratios
    localparam logic [1:0] CLK_SEL_DIV16 = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV8 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV1 = 2'h2;
    localparam logic [1:0] CLK_SEL_DIV2 = 2'h3;
    localparam logic [4:0] DIV_BY_16 = 5'h10;
    localparam logic [4:0] DIV_BY_8 = 5'h08;
    localparam logic [4:0] DIV_BY_1 = 5'h01;
    localparam logic [4:0] DIV_BY_2 = 5'h02;
    // Conversion timing in converter clocks
    localparam int STEP_TICKS = 4;
    localparam int CONV_STEPS = 16;
    localparam int CONV_TICKS = STEP_TICKS * CONV_STEPS;
    localparam int SAMPLE_STEPS = CONV_STEPS - RESULT_BITS;
    // Sequencer states
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT} seq_state_t;
endpackage

// file: shared/sar_if.sv
// Purpose: Link between register logic and the conversion sequencer
// Assumes: Both ends on the system clock
// Notes: start is a one-cycle request, abort a level held while disabled; done is a one-cycle pulse
`timescale 1ns/1ns
interface sar_if;
    logic start; // Begin a conversion
    logic abort; // Drop a running conversion
    logic [1:0] div_sel; // Converter clock select
    logic busy; // Conversion running
    logic done; // Conversion finished, result valid
    logic [adc_pkg::RESULT_BITS-1:0] result; // Finished code
    modport ctrl (output start, output abort, output div_sel,
        input busy, input done, input result);
    modport seq (input start, input abort, input div_sel,
        output busy, output done, output result);
endinterface

// file: rtl/sar_sequencer.sv
// Purpose: Divides the clock, times the conversion, runs the bit search
// Assumes: Comparator high when input is above the trial code
// Notes: 16 steps of 4 converter clocks; first 4 steps sample
`timescale 1ns/1ns
module sar_sequencer (
    input wire logic clock_i,
    input wire logic rst_n_i,
    sar_if.seq ctl,
    input wire logic compare_i,
    output logic [adc_pkg::RESULT_BITS-1:0] trial_code_o,
    output logic sample_o
);
    import adc_pkg::*;
    localparam int TICK_W = $clog2(CONV_TICKS);
    localparam int PHASE_W = $clog2(STEP_TICKS);
    localparam logic [PHASE_W-1:0] LAST_PHASE = PHASE_W'(STEP_TICKS - 1);
    localparam logic [TICK_W-PHASE_W-1:0] LAST_SAMPLE = (TICK_W-PHASE_W)'(SAMPLE_STEPS - 1);
    localparam logic [RESULT_BITS-1:0] MSB = {1'b1, {(RESULT_BITS-1){1'b0}}};

    // Total converter clock count must be a power of two and leave at least one sampling step
    if (CONV_TICKS != (1 << TICK_W) || SAMPLE_STEPS < 1) begin : g_timing_check
        $error("sar_sequencer: timing constants not supported");
    end

    seq_state_t state_r, state_nxt; // Sequencer state
    logic [4:0] div_r, div_nxt; // Latched divide ratio
    logic [4:0] pre_r, pre_nxt; // Prescaler
    logic [TICK_W-1:0] tick_r, tick_nxt; // Converter clock count
    logic [RESULT_BITS-1:0] sar_r, sar_nxt; // Trial code
    logic [RESULT_BITS-1:0] mask_r, mask_nxt; // Bit under test
    logic [RESULT_BITS-1:0] result_r, result_nxt; // Finished code
    logic done_r, done_nxt; // Finish pulse
    logic cmp_meta_r; // First sync stage, read only by the second
    logic cmp_sync_r; // Comparator, safe to use
    logic tick; // One converter clock elapsed
    logic [RESULT_BITS-1:0] decided; // Code with current bit decided

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        div_nxt = div_r;
        pre_nxt = pre_r;
        tick_nxt = tick_r;
        sar_nxt = sar_r;
        mask_nxt = mask_r;
        result_nxt = result_r;
        done_nxt = 1'b0;
        tick = (pre_r == div_r - 5'h01);
        decided = cmp_sync_r ? sar_r : (sar_r & ~mask_r);
        case (state_r)
            SEQ_IDLE: begin
                if (ctl.start) begin
                    case (ctl.div_sel)
                        CLK_SEL_DIV16: div_nxt = DIV_BY_16;
                        CLK_SEL_DIV8: div_nxt = DIV_BY_8;
                        CLK_SEL_DIV1: div_nxt = DIV_BY_1;
                        default: div_nxt = DIV_BY_2;
                    endcase
                    pre_nxt = 5'h00;
                    tick_nxt = '0;
                    sar_nxt = '0;
                    mask_nxt = '0;
                    state_nxt = SEQ_SAMPLE;
                end
            end
            SEQ_SAMPLE, SEQ_CONVERT: begin
                if (ctl.abort) begin
                    state_nxt = SEQ_IDLE;
                end else if (!tick) begin
                    pre_nxt = pre_r + 5'h01;
                end else begin
                    pre_nxt = 5'h00;
                    tick_nxt = tick_r + 1'b1;
                    if (tick_r[PHASE_W-1:0] == LAST_PHASE) begin
                        if (state_r == SEQ_SAMPLE) begin
                            // Sampling over: test the top bit first
                            if (tick_r[TICK_W-1:PHASE_W] == LAST_SAMPLE) begin
                                sar_nxt = MSB;
                                mask_nxt = MSB;
                                state_nxt = SEQ_CONVERT;
                            end
                        end else if (mask_r[0]) begin
                            // Last bit decided at the 64th converter clock
                            result_nxt = decided;
                            done_nxt = 1'b1;
                            state_nxt = SEQ_IDLE;
                        end else begin
                            sar_nxt = decided | (mask_r >> 1);
                            mask_nxt = mask_r >> 1;
                        end
                    end
                end
            end
            default: state_nxt = SEQ_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r <= SEQ_IDLE;
            div_r <= DIV_BY_16;
            pre_r <= 5'h00;
            tick_r <= '0;
            sar_r <= '0;
            mask_r <= '0;
            result_r <= '0;
            done_r <= 1'b0;
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            pre_r <= pre_nxt;
            tick_r <= tick_nxt;
            sar_r <= sar_nxt;
            mask_r <= mask_nxt;
            result_r <= result_nxt;
            done_r <= done_nxt;
            cmp_meta_r <= compare_i;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    assign ctl.busy = (state_r != SEQ_IDLE);
    assign ctl.done = done_r;
    assign ctl.result = result_r;
    assign trial_code_o = sar_r;
    assign sample_o = (state_r == SEQ_SAMPLE);
endmodule

// file: bench/adc_control_assertions.sv
// Purpose: Port-level checks of the converter control
// Assumes: One clock, synchronous active-low reset
// Notes: Bound into every adc_control instance
`timescale 1ns/1ns
module adc_control_assertions import adc_pkg::*; (
    input wire logic clock_i, rst_n_i, rd_i, wr_i, irq_ack_i, irq_o, wake_o, sample_o,
    input wire logic converter_enable_o, opamp_channel_en_o, battery_channel_en_o,
    input wire logic [7:0] addr_i, wdata_i, rdata_o,
    input wire logic [7:0] port1_analog_config_o, port2_analog_config_o,
    input wire logic [EXT_CHANNELS-1:0] ext_channel_en_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Sampling spans 16 converter clocks, at least 16 system cycles; the first 8 are checked, unless disabled
    sequence s_sampling; (sample_o || !converter_enable_o) [*8]; endsequence
    // Acknowledge with no fresh completion behind it
    sequence s_quiet_ack; irq_ack_i ##1 !wake_o ##1 !wake_o; endsequence
    a_one_input:
        assert property ($onehot0({ext_channel_en_o, opamp_channel_en_o, battery_channel_en_o}))
        else $error("two inputs connected");
    a_pin_fixed:
        assert property (!port1_analog_config_o[0] && port2_analog_config_o[7:6] == 2'h0)
        else $error("fixed pin bit set");
    a_wake_pulse:
        assert property (wake_o |=> !wake_o) else $error("wake longer than a cycle");
    a_wake_irq:
        assert property (wake_o |-> irq_o) else $error("wake without request");
    a_ack_clears:
        assert property (s_quiet_ack |-> !irq_o) else $error("request survives service");
    a_disable_off:
        assert property (wr_i && addr_i == MODE_ADDR && !wdata_i[MODE_EN_BIT]
            |-> ##1 !converter_enable_o) else $error("enable stays on");
    a_sample_span:
        assert property ($rose(sample_o) |-> s_sampling) else $error("sampling too short");
    a_read_idle:
        assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data not idle");
endmodule
bind adc_control adc_control_assertions u_adc_control_assertions (.*);

// file: bench/adc_core_model.sv
// Purpose: Comparator of the analog core seen from the control logic
// Assumes: Input level given as an ideal 12-bit code
// Notes: Combinational, no settling delay modelled
`timescale 1ns/1ns
module adc_core_model (
    input wire logic [adc_pkg::RESULT_BITS-1:0] trial_code_i,
    input wire logic [adc_pkg::RESULT_BITS-1:0] level_i,
    output logic compare_o
);
    // Half a step above the level keeps ties off the code
    assign compare_o = {level_i, 1'b1} > {trial_code_i, 1'b0};
endmodule

// file: bench/adc_control_tb.sv
// Purpose: Self-checking bench for the converter control
// Assumes: Core model answers the trial code
// Notes: Conversion time measured through wake_o
`timescale 1ns/1ns
module adc_control_tb;
    import adc_pkg::*;
    logic clock_i = 0, rst_n_i = 0, wr = 0, rd = 0, pwm = 0, ack = 0, cmp, irq, wake, en, smp;
    logic xr, opa, bat;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, p1, p2;
    logic [1:0] ir;
    logic [3:0] chs;
    logic [10:0] ext;
    logic [11:0] trial, level = 12'h000;
    int n_mismatch = 0, checks = 0, cyc = 0;
    adc_control u_adc_control (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pwm_generator_enable_i(pwm),
        .irq_ack_i(ack), .irq_o(irq), .wake_o(wake), .compare_i(cmp), .converter_enable_o(en),
        .sample_o(smp), .trial_code_o(trial), .channel_select_o(chs), .ext_channel_en_o(ext),
        .opamp_channel_en_o(opa), .battery_channel_en_o(bat), .external_reference_select_o(xr),
        .internal_reference_select_o(ir), .port1_analog_config_o(p1), .port2_analog_config_o(p2));
    adc_core_model u_adc_core_model (.trial_code_i(trial), .level_i(level), .compare_o(cmp));
    initial forever #25 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= cyc + 1;
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    // Strobe for one cycle, held until its own taken edge
    task automatic write_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clock_i) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clock_i) wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic read_reg(logic [7:0] a, logic [7:0] e, string s);
        @(posedge clock_i) {addr, rd} <= {a, 1'b1};
        @(posedge clock_i) rd <= 1'b0;
        #1 chk(s, e, rdata);
    endtask
    task automatic results;
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_reset;
        read_reg(MODE_ADDR, 8'h00, "mode");
        read_reg(8'h00, 8'h00, "unmapped");
        chk("enable", 0, en);
    endtask
    task automatic t_select;
        write_reg(RESULT_LOW_ADDR, 8'h60);
        for (int c = 0; c < 16; c++) begin
            write_reg(MODE_ADDR, 8'h80 | c[7:0]);
            repeat (2) @(posedge clock_i);
            #1 chk("chan", {c == 12, c == 11, 11'(c < 11 ? 1 << c : 0)}, {bat, opa, ext});
        end
        chk("code", 15, chs);
        write_reg(RESULT_LOW_ADDR, 8'h20);
        repeat (2) @(posedge clock_i);
        #1 chk("gate", 0, {bat, opa, ext});
        for (int v = 0; v < 4; v++) begin
            write_reg(REFERENCE_ADDR, v[7:0]);
            repeat (2) @(posedge clock_i);
            #1 chk("ref", v, {xr, ir});
        end
        write_reg(REFERENCE_ADDR, 8'h84);
        repeat (2) @(posedge clock_i);
        #1 chk("ref pin", 7, {xr, ir});
        write_reg(PORT1_CFG_ADDR, 8'h01);
        write_reg(PORT2_CFG_ADDR, 8'hC1);
        read_reg(PORT2_CFG_ADDR, 8'h01, "port2");
        chk("pins", 16'h0001, {p1, p2});
    endtask
    // Every clock rate, busy restart refused, result and flags after completion
    task automatic t_convert;
        int t0;
        logic [11:0] lv [4] = '{12'hFFF, 12'h5A3, 12'h001, 12'hA5C};
        int dv [4] = '{16, 8, 1, 2};
        write_reg(REFERENCE_ADDR, 8'h03);
        write_reg(IRQ_ENABLE_ADDR, 8'h02);
        for (int s = 0; s < 4; s++) begin
            level = lv[s];
            write_reg(RESULT_LOW_ADDR, 8'h40 | (s[7:0] << 4));
            write_reg(MODE_ADDR, 8'hC3);
            #1 t0 = cyc;
            read_reg(MODE_ADDR, 8'hC3, "busy");
            write_reg(MODE_ADDR, 8'hC3);
            while (wake !== 1'b1 && cyc - t0 < 1100) @(posedge clock_i) #1;
            chk("time", 1, cyc - t0 >= 64 * dv[s] + 1 && cyc - t0 <= 64 * dv[s] + 3);
            read_reg(MODE_ADDR, 8'hA3, "done");
            write_reg(RESULT_HIGH_ADDR, 8'h00);
            read_reg(RESULT_HIGH_ADDR, lv[s][11:4], "high");
            read_reg(RESULT_LOW_ADDR, {2'b01, s[1:0], lv[s][3:0]}, "low");
            read_reg(IRQ_FLAG_ADDR, 8'h01, "flag");
            chk("irq", 1, irq);
            @(posedge clock_i) ack <= 1'b1;
            @(posedge clock_i) ack <= 1'b0;
            read_reg(IRQ_FLAG_ADDR, 8'h00, "ack");
            write_reg(MODE_ADDR, 8'h83);
            read_reg(MODE_ADDR, 8'h83, "eoc clear");
        end
    endtask
    task automatic t_pwm;
        int w = 0;
        write_reg(RESULT_LOW_ADDR, 8'h60);
        write_reg(REFERENCE_ADDR, 8'h13);
        pwm <= 1'b1;
        repeat (300) @(posedge clock_i) #1 w += int'(wake === 1'b1);
        chk("pwm runs", 1, w >= 3);
        @(posedge clock_i) pwm <= 1'b0;
        repeat (100) @(posedge clock_i);
        read_reg(MODE_ADDR, 8'hA3, "pwm stop");
        write_reg(MODE_ADDR, 8'hC3);
        write_reg(MODE_ADDR, 8'h03);
        read_reg(MODE_ADDR, 8'h03, "abort");
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_select;
        t_convert;
        t_pwm;
        results;
    end
    // Cuts a hang well past the longest expected run
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        results;
    end
endmodule
